// ### iau_arith_unit.sv
// Overview of operation
// - when enabled, the selected operation is applied and the outcome driven out
// - first operand is the left term, second the right term
// - integer divide drops the fraction, never rounds to nearest
// - basic operations pass power flow when no overflow happens
// - overflow saturates to the largest magnitude with correct sign, no power flow
// - an invalid operation clears power flow even without overflow
// - operands and result share one type: 16-bit, 32-bit or real
// - 32-bit operands span the full signed 32-bit range
// - 32-bit values are two's complement across two 16-bit words
// - low word of a 32-bit value equals its 16-bit integer part
// - remainder is first minus truncated quotient times second
// - a nonzero remainder carries the sign of the first operand
// - remainder accepts only matching 16-bit or 32-bit integer types
// - remainder passes power flow unless the second operand is zero
`default_nettype none

module iau_arith_unit
    import iau_pkg::*;
(
    input  wire logic          clock,
    input  wire logic          rst,
    input  wire logic          enable,
    input  wire iau_op_type    op,
    input  wire iau_dtype_type data_type,
    input  wire logic [31:0]   first_operand,
    input  wire logic [31:0]   second_operand,
    output logic      [31:0]   result,
    output logic               power_out,
    output logic               result_valid
);

    // --------------------------------------------------------------
    // request decode
    // --------------------------------------------------------------
    logic               is_wide;
    logic               is_real;
    logic               is_int;
    logic               is_div;
    logic               is_mod;
    logic               type_ok;
    logic               op_ok;
    logic               bad_request;

    assign is_wide = (data_type == IAU_TYPE_INT32);
    assign is_real = (data_type == IAU_TYPE_REAL);
    assign is_int  = is_wide || (data_type == IAU_TYPE_INT16);
    assign is_div  = (op == IAU_OP_DIV);
    assign is_mod  = (op == IAU_OP_MOD);
    assign type_ok = is_int || is_real;
    assign op_ok   = (op == IAU_OP_ADD) || (op == IAU_OP_SUB) || (op == IAU_OP_MUL)
                  || is_div || is_mod;
    // a single type field means mixed widths cannot be requested at all
    assign bad_request = !type_ok || !op_ok || (is_mod && is_real);

    // --------------------------------------------------------------
    // integer datapath
    // --------------------------------------------------------------
    logic        [31:0] op_a;
    logic        [31:0] op_b;
    logic signed [63:0] a_w;
    logic signed [63:0] b_w;
    logic signed [63:0] sum_w;
    logic signed [63:0] diff_w;
    logic signed [63:0] prod_w;
    logic signed [32:0] quo;
    logic signed [32:0] rem;
    logic               div_zero;
    logic signed [63:0] raw;
    logic signed [31:0] lim_hi;
    logic signed [31:0] lim_lo;
    logic               int_ovf;
    logic               int_clip;
    logic               clip_neg;
    logic        [31:0] int_sat;
    logic        [31:0] int_value;
    logic               int_ok;

    // 16-bit operands use the low word only, sign extended
    assign op_a = is_wide ? first_operand
                          : {{16{first_operand[15]}}, first_operand[15:0]};
    assign op_b = is_wide ? second_operand
                          : {{16{second_operand[15]}}, second_operand[15:0]};
    // full 32-bit two's complement range on both inputs
    assign a_w  = {{32{op_a[31]}}, op_a};
    assign b_w  = {{32{op_b[31]}}, op_b};

    // wide arithmetic so no intermediate can wrap before the clip check
    assign sum_w  = a_w + b_w;
    assign diff_w = a_w - b_w;
    assign prod_w = a_w * b_w;

    iau_int_div u_int_div (
        .dividend  (a_w[32:0]),
        .divisor   (b_w[32:0]),
        .quotient  (quo),
        .remainder (rem),
        .div_zero  (div_zero)
    );

    assign raw = (op == IAU_OP_ADD) ? sum_w  :
                 (op == IAU_OP_SUB) ? diff_w :
                 (op == IAU_OP_MUL) ? prod_w :
                 is_div ? {{31{quo[32]}}, quo} : {{31{rem[32]}}, rem};

    assign lim_hi   = is_wide ? INT32_MAX : INT16_MAX;
    assign lim_lo   = is_wide ? INT32_MIN : INT16_MIN;
    assign int_ovf  = (raw > lim_hi) || (raw < lim_lo);
    // divide by zero clips toward the first operand's sign
    assign int_clip = int_ovf || (is_div && div_zero);
    assign clip_neg = (is_div && div_zero) ? a_w[63] : raw[63];
    assign int_sat  = int_clip ? (clip_neg ? lim_lo : lim_hi) : raw[31:0];
    // the remainder cannot overflow, its only failure is a zero divisor
    assign int_ok   = is_mod ? !div_zero : !int_clip;
    // a 16-bit result leaves the upper word clear
    assign int_value = is_wide ? int_sat : {UPPER_CLEAR, int_sat[15:0]};

    // --------------------------------------------------------------
    // floating point datapath
    // --------------------------------------------------------------
    logic        [31:0] real_value;
    logic               real_ovf;
    logic               real_invalid;

    iau_real_core u_real_core (
        .op       (op),
        .a        (first_operand),
        .b        (second_operand),
        .value    (real_value),
        .overflow (real_ovf),
        .invalid  (real_invalid)
    );

    // --------------------------------------------------------------
    // result select and output registers
    // --------------------------------------------------------------
    logic        [31:0] next_result;
    logic               next_ok;

    assign next_result = bad_request ? RESULT_RESET :
                         is_real ? real_value : int_value;
    assign next_ok     = !bad_request
                      && (is_real ? !(real_ovf || real_invalid) : int_ok);

    // result and power_out hold between operations so the sequencer may read late; result_valid follows enable
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            result       <= RESULT_RESET;
            power_out    <= 1'b0;
            result_valid <= 1'b0;
        end else begin
            result_valid <= enable;
            if (enable) begin
                result    <= next_result;
                power_out <= next_ok;
            end
        end
    end

    // --------------------------------------------------------------
    // assertions
    // --------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    a_result_capture:
    assert property (enable |=> result == $past(next_result) && power_out == $past(next_ok))
        else $error("result not captured on enable");

    a_result_hold:
    assert property (!enable |=> $stable(result) && $stable(power_out))
        else $error("result changed without enable");

    a_sub_order:
    assert property (enable && op == IAU_OP_SUB && data_type == IAU_TYPE_INT32 && !int_ovf
                     |=> result == $past(first_operand) - $past(second_operand))
        else $error("subtract operand order wrong");

    a_div_truncate:
    assert property (enable && is_div && data_type == IAU_TYPE_INT32 && !div_zero && !int_ovf
                     |=> $signed(result)
                         == $signed($past(first_operand)) / $signed($past(second_operand)))
        else $error("integer divide not truncated");

    a_add_ok_flag:
    assert property (enable && op == IAU_OP_ADD && data_type == IAU_TYPE_INT16
                     && sum_w <= 64'sh0000_0000_0000_7FFF
                     && sum_w >= -64'sh0000_0000_0000_8000
                     |=> power_out && result[15:0] == $past(sum_w[15:0]))
        else $error("valid add did not pass power flow");

    a_add_saturate:
    assert property (enable && op == IAU_OP_ADD && data_type == IAU_TYPE_INT32
                     && !first_operand[31] && !second_operand[31]
                     && sum_w[31]
                     |=> result == INT32_MAX && !power_out)
        else $error("positive overflow not saturated");

    a_real_saturate:
    assert property (enable && is_real && !bad_request && real_ovf && !real_invalid
                     |=> result[30:0] == REAL_SAT_MAG && !power_out)
        else $error("real overflow not saturated");

    a_invalid_clear:
    assert property (enable && (bad_request || (is_real && real_invalid)) |=> !power_out)
        else $error("invalid operation kept power flow");

    a_mod_sign:
    assert property (enable && is_mod && is_wide && !div_zero
                     |=> result == RESULT_RESET || result[31] == $past(first_operand[31]))
        else $error("remainder sign differs from first operand");

    a_mod_flag:
    assert property (enable && is_mod && is_int |=> power_out == !$past(div_zero))
        else $error("remainder flag wrong for divisor");

    a_int16_upper:
    assert property (enable && data_type == IAU_TYPE_INT16 && op_ok |=> result[31:16] == 16'h0000)
        else $error("16-bit result upper word not clear");

    a_real_unit_mul:
    assert property (enable && is_real && op == IAU_OP_MUL && second_operand == REAL_ONE
                     && first_operand[30:23] != 8'h00 && first_operand[30:23] != REAL_EXP_SPEC
                     |=> result == $past(first_operand) && power_out)
        else $error("real multiply by one altered value");

    a_valid_pulse:
    assert property (enable |=> result_valid ##1 (result_valid == $past(enable)))
        else $error("result valid pulse misplaced");

    c_int_overflow:
    cover property (enable && is_int && int_ovf ##1 !power_out);

    c_real_divide:
    cover property (enable && is_real && is_div && !real_invalid ##1 power_out);

    c_mod_negative:
    cover property (enable && is_mod && first_operand[31] && is_wide && !div_zero);

    c_div_by_zero:
    cover property (enable && is_div && is_int && div_zero ##1 !power_out);

endmodule : iau_arith_unit

`default_nettype wire

// ### iau_int_div.sv
`default_nettype none

module iau_int_div
    import iau_pkg::*;
(
    input  wire logic signed [32:0] dividend,
    input  wire logic signed [32:0] divisor,
    output logic signed      [32:0] quotient,
    output logic signed      [32:0] remainder,
    output logic                    div_zero
);

    logic [32:0] mag_a;
    logic [32:0] mag_b;
    logic [32:0] mag_q;
    logic [32:0] mag_r;

    // work on magnitudes so the quotient drops its fraction toward zero
    assign mag_a    = dividend[32] ? 33'(-dividend) : 33'(dividend);
    assign mag_b    = divisor[32] ? 33'(-divisor) : 33'(divisor);
    assign div_zero = (mag_b == '0);
    assign mag_q    = div_zero ? '0 : mag_a / mag_b;
    assign mag_r    = mag_a - 33'(mag_q * mag_b);

    assign quotient  = (dividend[32] ^ divisor[32]) ? -$signed(mag_q) : $signed(mag_q);
    // remainder follows the dividend sign only
    assign remainder = dividend[32] ? -$signed(mag_r) : $signed(mag_r);

endmodule : iau_int_div

`default_nettype wire

// ### iau_pkg.sv
`default_nettype none

package iau_pkg;

    // --------------------------------------------------------------
    // operation and operand type codes
    // --------------------------------------------------------------
    typedef enum logic [2:0] {
        IAU_OP_ADD = 3'b000,
        IAU_OP_SUB = 3'b001,
        IAU_OP_MUL = 3'b010,
        IAU_OP_DIV = 3'b011,
        IAU_OP_MOD = 3'b100
    } iau_op_type;

    typedef enum logic [1:0] {
        IAU_TYPE_INT16 = 2'b00,
        IAU_TYPE_INT32 = 2'b01,
        IAU_TYPE_REAL  = 2'b10
    } iau_dtype_type;

    // --------------------------------------------------------------
    // integer limits and word layout
    // --------------------------------------------------------------
    localparam logic signed [31:0] INT32_MAX    = 32'sh7FFF_FFFF;
    localparam logic signed [31:0] INT32_MIN    = 32'sh8000_0000;
    localparam logic signed [31:0] INT16_MAX    = 32'sh0000_7FFF;
    localparam logic signed [31:0] INT16_MIN    = 32'shFFFF_8000;
    localparam logic        [15:0] UPPER_CLEAR  = 16'h0000;
    localparam logic        [31:0] RESULT_RESET = 32'h0000_0000;

    // --------------------------------------------------------------
    // single precision layout
    // --------------------------------------------------------------
    localparam logic signed [12:0] REAL_EXP_BIAS = 13'sh007F;
    localparam logic signed [12:0] REAL_EXP_TOP  = 13'sh00FF;
    localparam logic        [7:0]  REAL_EXP_SPEC = 8'hFF;
    localparam logic        [30:0] REAL_SAT_MAG  = 31'h7F7F_FFFF;
    localparam logic        [31:0] REAL_ONE      = 32'h3F80_0000;

endpackage : iau_pkg

`default_nettype wire

// ### iau_real_core.sv
`default_nettype none

module iau_real_core
    import iau_pkg::*;
(
    input  wire iau_op_type  op,
    input  wire logic [31:0] a,
    input  wire logic [31:0] b,
    output logic      [31:0] value,
    output logic             overflow,
    output logic             invalid
);

    // --------------------------------------------------------------
    // normalise a wide significand; denormals flush to zero
    // --------------------------------------------------------------
    function automatic logic [32:0] pack_real(
        input logic               sgn,
        input logic signed [12:0] exp_in,
        input logic        [51:0] m,
        input logic signed [12:0] frac
    );
        logic signed [12:0] e;
        logic        [51:0] n;
        int                 top;
        top = 0;
        for (int i = 0; i < 52; i++) begin
            if (m[i]) begin
                top = i;
            end
        end
        e = exp_in + 13'(top) - frac;
        n = (top >= 23) ? (m >> (top - 23)) : (m << (23 - top));
        if (m == '0 || e <= 0) begin
            return {2'b00, 31'h0000_0000};
        end else if (e >= REAL_EXP_TOP) begin
            return {1'b1, sgn, REAL_SAT_MAG};
        end
        return {1'b0, sgn, e[7:0], n[22:0]};
    endfunction : pack_real

    logic [7:0]  exp_a;
    logic [7:0]  exp_b;
    logic [23:0] man_a;
    logic [23:0] man_b;
    logic        sign_b;
    logic        a_big;
    logic [7:0]  big_e;
    logic [23:0] big_m;
    logic        big_s;
    logic [7:0]  sml_e;
    logic [23:0] sml_m;
    logic        sml_s;
    logic [7:0]  shift;
    logic [51:0] big_w;
    logic [51:0] sml_w;
    logic [51:0] sum_w;
    logic [51:0] prod_w;
    logic [51:0] quo_w;
    logic [32:0] add_pk;
    logic [32:0] mul_pk;
    logic [32:0] div_pk;
    logic [32:0] sel_pk;

    // 32-bit single precision: 24 significant bits with the hidden one
    assign exp_a = a[30:23];
    assign exp_b = b[30:23];
    assign man_a = (exp_a == 8'h00) ? 24'h00_0000 : {1'b1, a[22:0]};
    assign man_b = (exp_b == 8'h00) ? 24'h00_0000 : {1'b1, b[22:0]};

    // --------------------------------------------------------------
    // add and subtract; second operand sign flips for subtract
    // --------------------------------------------------------------
    assign sign_b = b[31] ^ (op == IAU_OP_SUB);
    assign a_big  = {exp_a, man_a} >= {exp_b, man_b};
    assign big_e  = a_big ? exp_a : exp_b;
    assign big_m  = a_big ? man_a : man_b;
    assign big_s  = a_big ? a[31] : sign_b;
    assign sml_e  = a_big ? exp_b : exp_a;
    assign sml_m  = a_big ? man_b : man_a;
    assign sml_s  = a_big ? sign_b : a[31];
    assign shift  = big_e - sml_e;
    assign big_w  = {28'h000_0000, big_m} << 26;
    assign sml_w  = (shift > 8'd49) ? '0 : (({28'h000_0000, sml_m} << 26) >> shift);
    assign sum_w  = (big_s == sml_s) ? big_w + sml_w : big_w - sml_w;
    assign add_pk = pack_real(big_s, $signed({5'h00, big_e}), sum_w, 13'sh0031);

    // --------------------------------------------------------------
    // multiply and divide
    // --------------------------------------------------------------
    // operands widened first: a product inside a concatenation keeps only its own width
    assign prod_w = {4'h0, 48'(man_a) * 48'(man_b)};
    assign mul_pk = pack_real(a[31] ^ b[31],
                              $signed({5'h00, exp_a}) + $signed({5'h00, exp_b}) - REAL_EXP_BIAS,
                              prod_w, 13'sh002E);
    // truncating quotient; the divider is guarded against a zero divisor
    assign quo_w  = (man_b == '0) ? '0 : {2'b00, man_a, 26'h000_0000} / {28'h000_0000, man_b};
    assign div_pk = pack_real(a[31] ^ b[31],
                              $signed({5'h00, exp_a}) - $signed({5'h00, exp_b}) + REAL_EXP_BIAS,
                              quo_w, 13'sh001A);

    assign sel_pk   = (op == IAU_OP_MUL) ? mul_pk :
                      (op == IAU_OP_DIV) ? div_pk : add_pk;
    // infinities and NaN are refused, as is a divide by zero
    assign invalid  = (exp_a == REAL_EXP_SPEC) || (exp_b == REAL_EXP_SPEC)
                   || ((op == IAU_OP_DIV) && (man_b == '0));
    assign overflow = sel_pk[32];
    assign value    = invalid ? {a[31] ^ b[31], REAL_SAT_MAG} : sel_pk[31:0];

endmodule : iau_real_core

`default_nettype wire

// ### iau_seq_model.sv
`default_nettype none

module iau_seq_model
    import iau_pkg::*;
(
    input  wire logic          clock,
    output var  logic          enable,
    output var  iau_op_type    op,
    output var  iau_dtype_type data_type,
    output var  logic [31:0]   first_operand,
    output var  logic [31:0]   second_operand
);
    timeunit 1ns;
    timeprecision 1ns;

    // expected real outcome travels with the request it belongs to
    logic [32:0] hint;

    initial begin
        enable = 1'b0;
        op = IAU_OP_ADD;
        data_type = IAU_TYPE_INT16;
        first_operand = 32'h0000_0000;
        second_operand = 32'h0000_0000;
        hint = 33'h0_0000_0000;
    end

    // --------------------------------------------------------------
    // requests
    // --------------------------------------------------------------
    task automatic issue(input logic [2:0] o, input logic [1:0] t, input logic [31:0] a,
                         input logic [31:0] b, input logic [32:0] h);
        @(posedge clock);
        enable <= 1'b1;
        op <= iau_op_type'(o);
        // one type code qualifies both operands and the result
        data_type <= iau_dtype_type'(t);
        // int16 requests carry junk upper words, int32 ones the full range
        first_operand <= (t == 2'd0) ? {~a[15:0], a[15:0]} : a;
        second_operand <= (t == 2'd0) ? {b[15:0], ~b[15:0]} : b;
        hint <= h;
    endtask : issue

    task automatic idle();
        @(posedge clock);
        enable <= 1'b0;
        // unqualified operands keep moving so a held result cannot follow them
        first_operand <= ~first_operand;
        second_operand <= ~second_operand;
    endtask : idle

    // sign fill of the upper word
    function automatic logic [31:0] widen(input logic [15:0] v);
        return {{16{v[15]}}, v};
    endfunction : widen

endmodule : iau_seq_model

`default_nettype wire

// ### tb.sv
`default_nettype none

module tb
    import iau_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int LIMIT = 3000;

    logic          clock;
    logic          rst;
    logic          enable;
    iau_op_type    op;
    iau_dtype_type data_type;
    logic [31:0]   first_operand;
    logic [31:0]   second_operand;
    logic [31:0]   result;
    logic          power_out;
    logic          result_valid;
    logic [31:0]   er;
    logic          eok;
    logic          pend;
    logic [2:0]    o;
    logic [1:0]    t;
    logic [31:0]   a;
    logic [31:0]   b;
    int            bad_count;
    int            n_checks;
    int            cycles;
    integer        seed;

    iau_arith_unit i_dut (.clock(clock), .rst(rst), .enable(enable), .op(op),
        .data_type(data_type), .first_operand(first_operand),
        .second_operand(second_operand), .result(result), .power_out(power_out),
        .result_valid(result_valid));

    iau_seq_model i_seq (.clock(clock), .enable(enable), .op(op), .data_type(data_type),
        .first_operand(first_operand), .second_operand(second_operand));

    // --------------------------------------------------------------
    // reference model
    // --------------------------------------------------------------
    function automatic logic [32:0] model(input logic [2:0] o, input logic [1:0] t,
        input logic [31:0] a, input logic [31:0] b, input logic [32:0] h);
        longint x;
        longint y;
        longint q;
        longint lo;
        longint hi;
        if (o > 3'd4 || t == 2'd3 || (o == 3'd4 && t == 2'd2))
            return 33'h0_0000_0000;
        if (t == 2'd2) begin
            // special exponents and zero divisors only; other real results come as hints
            if (a[30:23] == REAL_EXP_SPEC || b[30:23] == REAL_EXP_SPEC ||
                (o == 3'd3 && b[30:0] == 31'h0))
                return {1'b0, a[31] ^ b[31], REAL_SAT_MAG};
            return h;
        end
        x = t[0] ? longint'($signed(a)) : longint'($signed(a[15:0]));
        y = t[0] ? longint'($signed(b)) : longint'($signed(b[15:0]));
        hi = t[0] ? longint'(INT32_MAX) : longint'(INT16_MAX);
        lo = t[0] ? longint'(INT32_MIN) : longint'(INT16_MIN);
        case (o)
            3'd0: q = x + y;
            3'd1: q = x - y;
            3'd2: q = x * y;
            3'd3: q = (y == 0) ? ((x < 0) ? lo - 1 : hi + 1) : x / y;
            default: begin
                if (y == 0) return {1'b0, t[0] ? a : {16'h0000, a[15:0]}};
                q = x - (x / y) * y;
            end
        endcase
        if (q > hi) return {1'b0, t[0] ? hi[31:0] : {16'h0000, hi[15:0]}};
        if (q < lo) return {1'b0, t[0] ? lo[31:0] : {16'h0000, lo[15:0]}};
        return {1'b1, t[0] ? q[31:0] : {16'h0000, q[15:0]}};
    endfunction : model

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: result %h, expected %h", $time, got, exp);
        end
    endtask : cmp_word

    task automatic cmp_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: flag %b, expected %b", $time, got, exp);
        end
    endtask : cmp_bit

    task automatic end_sim();
        $display("checks %0d, mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_sim

    task automatic d(input logic [2:0] o, input logic [1:0] t, input logic [31:0] a,
                     input logic [31:0] b);
        i_seq.issue(o, t, a, b, 33'h0_0000_0000);
    endtask : d

    // --------------------------------------------------------------
    // clock, expectation and checking
    // --------------------------------------------------------------
    always #25 clock = ~clock;

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            bad_count++;
            end_sim();
        end
    end

    // cleared at once, as the design clears its outputs asynchronously
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            pend <= 1'b0;
            er <= RESULT_RESET;
            eok <= 1'b0;
        end else begin
            pend <= enable;
            if (enable === 1'b1) begin
                {eok, er} <= model(op, data_type, first_operand, second_operand, i_seq.hint);
            end
        end
    end

    always @(negedge clock) begin
        cmp_bit(result_valid, pend);
        cmp_word(result, er);
        cmp_bit(power_out, eok);
    end

    // --------------------------------------------------------------
    // stimulus
    // --------------------------------------------------------------
    initial begin
        seed = 32'h2f52_aecd;
        clock = 1'b0;
        rst = 1'b1;
        bad_count = 0;
        n_checks = 0;
        cycles = 0;
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        d(3'd0, 2'd0, 32'h0000_7fff, 32'h0000_0001);
        d(3'd0, 2'd0, 32'h0000_8000, 32'h0000_ffff);
        d(3'd1, 2'd0, 32'h0000_0003, 32'h0000_0007);
        d(3'd2, 2'd0, 32'h0000_0100, 32'h0000_0100);
        d(3'd3, 2'd0, 32'h0000_0018, 32'h0000_0005);
        d(3'd3, 2'd0, 32'h0000_8000, 32'h0000_ffff);
        d(3'd3, 2'd0, 32'h0000_fffb, 32'h0000_0000);
        d(3'd4, 2'd0, 32'h0000_fff9, 32'h0000_0002);
        d(3'd4, 2'd0, 32'h0000_0007, 32'h0000_fffe);
        d(3'd4, 2'd0, 32'h0000_0005, 32'h0000_0000);
        d(3'd0, 2'd1, 32'h7fff_ffff, 32'h0000_0001);
        d(3'd1, 2'd1, 32'h8000_0000, 32'h0000_0001);
        d(3'd2, 2'd1, 32'h0001_0000, 32'h0001_0000);
        d(3'd3, 2'd1, 32'h8000_0000, 32'hffff_ffff);
        d(3'd4, 2'd1, 32'h8000_0000, 32'h0000_0003);
        d(3'd4, 2'd1, 32'hffff_fff9, 32'h0000_0000);
        for (int k = 5; k < 8; k++) begin
            d(3'(k), 2'd1, 32'h0000_0004, 32'h0000_0002);
        end
        d(3'd0, 2'd3, 32'h0000_0004, 32'h0000_0002);
        d(3'd4, 2'd2, 32'h3f80_0000, 32'h3f80_0000);
        i_seq.issue(3'd2, 2'd2, 32'h4000_0000, 32'h4040_0000, {1'b1, 32'h40c0_0000});
        i_seq.issue(3'd3, 2'd2, 32'h40c0_0000, 32'h4000_0000, {1'b1, 32'h4040_0000});
        i_seq.issue(3'd1, 2'd2, 32'hff7f_ffff, 32'h7f7f_ffff, {1'b0, 32'hff7f_ffff});
        d(3'd0, 2'd2, 32'h7fc0_0000, 32'h3f80_0000);
        d(3'd3, 2'd2, 32'h3f80_0000, 32'h8000_0000);
        i_seq.idle();
        @(posedge clock);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        repeat (300) begin
            o = 3'($unsigned($random(seed)) % 5);
            t = 2'($unsigned($random(seed)) % 2);
            a = $random(seed);
            b = $random(seed);
            if (a[3]) b = {{28{a[9]}}, b[3:0]};
            if (t[0] && a[4]) begin
                a = i_seq.widen(a[15:0]);
                b = i_seq.widen(b[15:0]);
            end else if (a[4]) begin
                // int16 operand as the low word of an in-range 32-bit value
                a = i_seq.widen(a[15:0]);
            end
            i_seq.issue(o, t, a, b, 33'h0_0000_0000);
            if (a[5] & b[6]) i_seq.idle();
        end
        i_seq.idle();
        repeat (3) @(posedge clock);
        end_sim();
    end

endmodule : tb

`default_nettype wire
